// File: core/iep_defs.vh
`ifndef IEP_DEFS_VH
`define IEP_DEFS_VH

// ==========================================
// Register offsets
`define IEP_OFS_EN0       8'hA8
`define IEP_OFS_EN1       8'hB1
`define IEP_OFS_PRL1      8'hB2
`define IEP_OFS_PRU1      8'hB3
`define IEP_OFS_PRU0      8'hB7
`define IEP_OFS_PRL0      8'hB8
`define IEP_OFS_STATUS    8'hC0
`define IEP_OFS_MASK      8'hC1

// ==========================================
// Field positions and writable masks
`define IEP_BIT_GLOBAL    7
`define IEP_WMASK_EN0     8'hFF
`define IEP_WMASK_GRP0    8'h7F
`define IEP_WMASK_GRP1    8'h57
`define IEP_WMASK_EVT     8'h07
`define IEP_EVT_TAKEN     0
`define IEP_EVT_PREEMPT   1
`define IEP_EVT_BADRET    2

// ==========================================
// Reset values
`define IEP_RST_REG       8'h00
`define IEP_RST_VEC       16'h0000

// ==========================================
// Vector layout
`define IEP_VEC_BASE      16'h0003
`define IEP_VEC_STEP      16'h0008

`endif

// File: core/iep_regs.v
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`include "iep_defs.vh"

// Operation
// - All sources are blocked while the global enable bit 7 of the first enable register is zero.
// - With global enable set, a source is forwarded only when its own enable bit is set.
// - First enable register: audio 6, decoder 5, serial 4, timer1 3, ext1 2, timer0 1, ext0 0.
// - Second enable register: USB 6, keypad 4, SPI 2, two-wire 1, card 0.
// - Bits 7, 5 and 3 of the second enable and second upper priority registers read zero.
// - Bit 7 of the first-group priority registers is reserved and never used by the logic.
// - First-group upper priority register holds each source's upper level bit, audio 6 to ext0 0.
// - First-group lower priority register holds each source's lower level bit, audio 6 to ext0 0.
// - Second-group upper priority register: USB 6, keypad 4, SPI 2, two-wire 1, card 0.
// - Second-group lower priority register has the same layout and its reserved bits read zero.
// - Upper and lower bits form a level 0 to 3, with 3 the highest.
// - A handler in service is pre-empted only by a request of strictly higher level.
// - Equal-level requests are chosen by fixed polling order, ext0 first, vectors 8 bytes apart.
module iep_regs #(
    parameter NSRC = 15
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset,
    // Register port
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    output reg [7:0] regRdData,
    // Request lines, indexed by polling slot
    input wire [NSRC-1:0] srcReq,
    // Core handshake
    output reg irqReq,
    output reg [15:0] irqVector,
    output reg [1:0] irqLevel,
    input wire irqAck,
    input wire irqReturn,
    output reg [NSRC-1:0] srcAck,
    // Event interrupt
    output wire irqOut
);

    // ==========================================
    // Highest level in service
    function [2:0] topLevel;
        input [3:0] svc;
        begin
            if (svc[3]) begin
                topLevel = 3'b111;
            end else if (svc[2]) begin
                topLevel = 3'b110;
            end else if (svc[1]) begin
                topLevel = 3'b101;
            end else if (svc[0]) begin
                topLevel = 3'b100;
            end else begin
                topLevel = 3'b000;
            end
        end
    endfunction

    // ==========================================
    // Registers
    reg [7:0] enable0_r;
    reg [7:0] enable1_r;
    reg [7:0] prioUpper0_r;
    reg [7:0] prioLower0_r;
    reg [7:0] prioUpper1_r;
    reg [7:0] prioLower1_r;
    reg [7:0] evtStatus_r;
    reg [7:0] evtMask_r;
    reg [3:0] inService_r;
    reg [7:0] evtStatus_nxt;
    reg [3:0] inService_nxt;

    wire wrEn0 = regWr && (regAddr == `IEP_OFS_EN0);
    wire wrEn1 = regWr && (regAddr == `IEP_OFS_EN1);
    wire wrPu0 = regWr && (regAddr == `IEP_OFS_PRU0);
    wire wrPl0 = regWr && (regAddr == `IEP_OFS_PRL0);
    wire wrPu1 = regWr && (regAddr == `IEP_OFS_PRU1);
    wire wrPl1 = regWr && (regAddr == `IEP_OFS_PRL1);
    wire wrMsk = regWr && (regAddr == `IEP_OFS_MASK);
    wire rdSts = regRd && (regAddr == `IEP_OFS_STATUS);

    // ==========================================
    // Per-slot views; reserved slots 10, 12, 14 stay disabled
    wire [NSRC-1:0] slotEn;
    wire [NSRC-1:0] slotUp;
    wire [NSRC-1:0] slotLo;
    assign slotEn = {1'b0, enable1_r[6], 1'b0, enable1_r[4], 1'b0,
                     enable1_r[2:0], enable0_r[6:0]};
    assign slotUp = {1'b0, prioUpper1_r[6], 1'b0, prioUpper1_r[4], 1'b0,
                     prioUpper1_r[2:0], prioUpper0_r[6:0]};
    assign slotLo = {1'b0, prioLower1_r[6], 1'b0, prioLower1_r[4], 1'b0,
                     prioLower1_r[2:0], prioLower0_r[6:0]};

    wire globalEn = enable0_r[`IEP_BIT_GLOBAL];
    wire [NSRC-1:0] cand;
    wire [2*NSRC-1:0] slotLvl;

    genvar g;
    generate
        for (g = 0; g < NSRC; g = g + 1) begin : gSlot
            assign cand[g] = globalEn && slotEn[g] && srcReq[g];
            assign slotLvl[2*g+1:2*g] = {slotUp[g], slotLo[g]};
        end
    endgenerate

    // ==========================================
    // Arbitration
    reg found;
    reg [1:0] bestLvl;
    reg [3:0] bestIdx;
    integer i;
    always @* begin
        found = 1'b0;
        bestLvl = 2'b00;
        bestIdx = 4'h0;
        // Downward scan so the lowest slot wins ties
        for (i = NSRC - 1; i >= 0; i = i - 1) begin
            if (cand[i] && (!found || slotLvl[2*i+1 -: 2] >= bestLvl)) begin
                found = 1'b1;
                bestLvl = slotLvl[2*i+1 -: 2];
                bestIdx = i[3:0];
            end
        end
    end

    wire [2:0] curTop = topLevel(inService_r);
    wire permit = found && (!curTop[2] || bestLvl > curTop[1:0]);
    wire take = irqAck && irqReq;
    wire [15:0] vecCalc = `IEP_VEC_BASE + ({12'h000, bestIdx} * `IEP_VEC_STEP);
    reg [3:0] takenIdx_r;

    // ==========================================
    // Service stack and events
    always @* begin
        inService_nxt = inService_r;
        evtStatus_nxt = evtStatus_r;
        if (rdSts) begin
            evtStatus_nxt = 8'h00;
        end
        if (irqReturn) begin
            if (curTop[2]) begin
                inService_nxt[curTop[1:0]] = 1'b0;
            end else begin
                evtStatus_nxt[`IEP_EVT_BADRET] = 1'b1;
            end
        end
        if (take) begin
            inService_nxt[irqLevel] = 1'b1;
            evtStatus_nxt[`IEP_EVT_TAKEN] = 1'b1;
            if (curTop[2]) begin
                evtStatus_nxt[`IEP_EVT_PREEMPT] = 1'b1;
            end
        end
    end

    assign irqOut = |(evtStatus_r & evtMask_r);

    // ==========================================
    // Register file
    // Enable register, group 0
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable0_r <= `IEP_RST_REG;
        end else if (wrEn0) begin
            enable0_r <= regWrData & `IEP_WMASK_EN0;
        end
    end

    // Enable register, group 1
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            enable1_r <= `IEP_RST_REG;
        end else if (wrEn1) begin
            enable1_r <= regWrData & `IEP_WMASK_GRP1;
        end
    end

    // Upper priority bits, group 0
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prioUpper0_r <= `IEP_RST_REG;
        end else if (wrPu0) begin
            prioUpper0_r <= regWrData & `IEP_WMASK_GRP0;
        end
    end

    // Lower priority bits, group 0
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prioLower0_r <= `IEP_RST_REG;
        end else if (wrPl0) begin
            prioLower0_r <= regWrData & `IEP_WMASK_GRP0;
        end
    end

    // Upper priority bits, group 1
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prioUpper1_r <= `IEP_RST_REG;
        end else if (wrPu1) begin
            prioUpper1_r <= regWrData & `IEP_WMASK_GRP1;
        end
    end

    // Lower priority bits, group 1
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            prioLower1_r <= `IEP_RST_REG;
        end else if (wrPl1) begin
            prioLower1_r <= regWrData & `IEP_WMASK_GRP1;
        end
    end

    // Event mask
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            evtMask_r <= `IEP_RST_REG;
        end else if (wrMsk) begin
            evtMask_r <= regWrData & `IEP_WMASK_EVT;
        end
    end

    // Event status and service stack
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            evtStatus_r <= `IEP_RST_REG;
            inService_r <= 4'h0;
        end else begin
            evtStatus_r <= evtStatus_nxt;
            inService_r <= inService_nxt;
        end
    end

    // ==========================================
    // Core handshake
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irqReq <= 1'b0;
            irqVector <= `IEP_RST_VEC;
            irqLevel <= 2'b00;
            takenIdx_r <= 4'h0;
            srcAck <= {NSRC{1'b0}};
        end else begin
            // Request dropped for the cycle after the ack so one grant per ack
            irqReq <= permit && !take;
            irqVector <= vecCalc;
            irqLevel <= bestLvl;
            takenIdx_r <= bestIdx;
            srcAck <= {NSRC{1'b0}};
            if (take) begin
                srcAck[takenIdx_r] <= 1'b1;
            end
        end
    end

    // ==========================================
    // Read port
    function [7:0] readMux;
        input [7:0] addr;
        begin
            case (addr)
                `IEP_OFS_EN0: readMux = enable0_r;
                `IEP_OFS_EN1: readMux = enable1_r;
                `IEP_OFS_PRU0: readMux = prioUpper0_r;
                `IEP_OFS_PRL0: readMux = prioLower0_r;
                `IEP_OFS_PRU1: readMux = prioUpper1_r;
                `IEP_OFS_PRL1: readMux = prioLower1_r;
                `IEP_OFS_STATUS: readMux = evtStatus_r;
                `IEP_OFS_MASK: readMux = evtMask_r;
                default: readMux = 8'h00;
            endcase
        end
    endfunction

    // Data stand one cycle after the strobe, zero otherwise
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            regRdData <= `IEP_RST_REG;
        end else if (regRd) begin
            regRdData <= readMux(regAddr);
        end else begin
            regRdData <= 8'h00;
        end
    end

endmodule // iep_regs

// File: test/iep_core_model.sv
`timescale 1ns/10ps
module iep_core_model (
    // Clock, reset, handshake
    input wire clk_sys,
    input wire reset,
    input wire irqReq,
    input wire autoAck,
    input wire [3:0] ackWait,
    output reg irqAck
);
    reg [3:0] waitCnt;
    wire hit = waitCnt == ackWait;
    always @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            irqAck <= 1'b0;
            waitCnt <= 4'h0;
        end else begin
            irqAck <= autoAck && irqReq && !irqAck && hit;
            if (autoAck && irqReq && !irqAck) waitCnt <= hit ? 4'h0 : waitCnt + 4'h1;
        end
    end
endmodule // iep_core_model

// File: test/iep_regs_sva.sv
`timescale 1ns/10ps
module iep_regs_sva #(
    parameter NSRC = 15
) (
    // Watched ports
    input wire clk_sys,
    input wire reset,
    input wire [7:0] regAddr,
    input wire [7:0] regWrData,
    input wire regWr,
    input wire regRd,
    input wire [7:0] regRdData,
    input wire irqReq,
    input wire [15:0] irqVector,
    input wire [1:0] irqLevel,
    input wire irqAck,
    input wire [NSRC-1:0] srcAck
);
    reg gEn_r;
    always @(posedge clk_sys or posedge reset) begin
        if (reset) gEn_r <= 1'b0;
        else if (regWr && regAddr == 8'hA8) gEn_r <= regWrData[7];
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_take; irqAck && irqReq; endsequence
    sequence s_rd1; regRd && (regAddr == 8'hB1 || regAddr == 8'hB2 || regAddr == 8'hB3); endsequence
    sequence s_rd0; regRd && (regAddr == 8'hB7 || regAddr == 8'hB8); endsequence
    property p_gbl; !gEn_r |=> !irqReq; endproperty
    a_gbl: assert property (p_gbl) else $error("request with global enable off");
    property p_rsv; s_rd1 |=> (regRdData & 8'hA8) == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit read as one");
    property p_rsv0; s_rd0 |=> !regRdData[7]; endproperty
    a_rsv0: assert property (p_rsv0) else $error("bit 7 read as one");
    property p_vec; irqReq |-> irqVector[2:0] == 3'h3 && irqVector <= 16'h0073; endproperty
    a_vec: assert property (p_vec) else $error("vector off the grid");
    property p_ack; s_take |=> $onehot(srcAck) && !irqReq; endproperty
    a_ack: assert property (p_ack) else $error("ack not answered");
    property p_noack; !(irqAck && irqReq) |=> srcAck == '0; endproperty
    a_noack: assert property (p_noack) else $error("ack pulse without take");
    property p_pre; s_take ##0 irqLevel == 2'h3 |=> !irqReq [*2]; endproperty
    a_pre: assert property (p_pre) else $error("top level pre-empted");
    property p_rdz; !regRd |=> regRdData == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("read data outside its cycle");
endmodule // iep_regs_sva
bind iep_regs iep_regs_sva #(.NSRC(NSRC)) sva_u (.clk_sys(clk_sys), .reset(reset),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel),
    .irqAck(irqAck), .srcAck(srcAck));

// File: test/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {logic [7:0] a, d, r; logic q; logic [15:0] v; logic [1:0] l;} iep_row_t;
    logic clk_sys = 1'b0, reset = 1'b1, regWr = 1'b0, regRd = 1'b0, autoAck = 1'b0;
    logic irqReturn = 1'b0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, rdVal;
    logic [14:0] srcReq = 15'h0000;
    logic [3:0] ackWait = 4'h0;
    wire [7:0] regRdData;
    wire irqReq, irqAck, irqOut;
    wire [15:0] irqVector;
    wire [1:0] irqLevel;
    wire [14:0] srcAck;
    int fail_count = 0, n_checks = 0, i, j;
    iep_row_t rows [10];
    iep_regs #(.NSRC(15)) dut_u (.clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
        .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .srcReq(srcReq), .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel),
        .irqAck(irqAck), .irqReturn(irqReturn), .srcAck(srcAck), .irqOut(irqOut));
    iep_core_model core_u (.clk_sys(clk_sys), .reset(reset), .irqReq(irqReq),
        .autoAck(autoAck), .ackWait(ackWait), .irqAck(irqAck));
    initial forever #2.5 clk_sys = ~clk_sys;
    initial begin
        #5000 fail_count++;
        stop_test();
    end
    task automatic stop_test();
        if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [26:0] got, input logic [26:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        {regWr, regRd, regAddr, regWrData} <= {w, !w, a, d};
        @(posedge clk_sys);
        {regWr, regRd} <= 2'b00;
        #1 rdVal = regRdData;
    endtask
    initial begin
        rows = '{'{8'hA8, 8'h7F, 8'h7F, 1'b0, 16'h0000, 2'h0},
            '{8'hA8, 8'h80, 8'h80, 1'b0, 16'h0000, 2'h0},
            '{8'hB1, 8'h57, 8'h57, 1'b1, 16'h003B, 2'h0},
            '{8'hA8, 8'hFF, 8'hFF, 1'b1, 16'h0003, 2'h0},
            '{8'hB3, 8'h57, 8'h57, 1'b1, 16'h003B, 2'h2},
            '{8'hB2, 8'h57, 8'h57, 1'b1, 16'h003B, 2'h3},
            '{8'hB7, 8'h7F, 8'h7F, 1'b1, 16'h003B, 2'h3},
            '{8'hB8, 8'h7F, 8'h7F, 1'b1, 16'h0003, 2'h3},
            '{8'hC1, 8'h07, 8'h07, 1'b1, 16'h0003, 2'h3},
            '{8'h50, 8'hFF, 8'h00, 1'b1, 16'h0003, 2'h3}};
        repeat (4) @(posedge clk_sys);
        {reset, srcReq} <= {1'b0, 15'h7FFF};
        for (i = 0; i < 10; i++) begin
            bus(1'b1, rows[i].a, rows[i].d);
            bus(1'b0, rows[i].a, 8'h00);
            chk({rdVal, irqReq, rows[i].q ? {irqVector, irqLevel} : 18'h0}, rows[i][26:0]);
        end
        @(posedge clk_sys) {reset, srcReq} <= {1'b1, 15'h0000};
        @(posedge clk_sys) reset <= 1'b0;
        for (i = 0; i < 10; i++) begin
            bus(1'b0, rows[i].a, 8'h00);
            chk({19'h0, rdVal}, 27'h0);
        end
        bus(1'b1, 8'hA8, 8'hFF);
        bus(1'b1, 8'hC1, 8'h07);
        @(posedge clk_sys) {srcReq, autoAck} <= {15'h0008, 1'b1};
        for (i = 0; i < 20 && srcAck === 15'h0; i++) @(posedge clk_sys) #1;
        chk({12'h0, srcAck}, 27'h8);
        bus(1'b1, 8'hB7, 8'h01);
        bus(1'b1, 8'hB8, 8'h01);
        chk({26'h0, irqReq}, 27'h0);
        @(posedge clk_sys) {srcReq, ackWait} <= {15'h0009, 4'h3};
        for (i = 0; i < 20 && srcAck === 15'h0; i++) @(posedge clk_sys) #1;
        chk({12'h0, srcAck}, 27'h1);
        bus(1'b0, 8'hC0, 8'h00);
        chk({18'h0, rdVal, irqOut}, 27'h6);
        @(posedge clk_sys) {srcReq, autoAck} <= {15'h0000, 1'b0};
        for (j = 0; j < 2; j++) begin
            bus(1'b1, 8'hC1, j ? 8'h00 : 8'h07);
            for (i = 0; i < (j ? 1 : 3); i++) begin
                @(posedge clk_sys) irqReturn <= 1'b1;
                @(posedge clk_sys) irqReturn <= 1'b0;
            end
            repeat (2) @(posedge clk_sys) #1;
            chk({26'h0, irqOut}, j ? 27'h0 : 27'h1);
            bus(1'b0, 8'hC0, 8'h00);
            chk({18'h0, rdVal, irqOut}, 27'h8);
        end
        stop_test();
    end
endmodule // tb_top
